// *** rtl/plc_params.svh ***
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH

// Register indices (word address on the slave port)
`define PLC_IDX_PATTERN_CTRL     5'h0a
`define PLC_IDX_LOOPBACK_CTRL    5'h0b
`define PLC_IDX_CODE_LENGTH_CTRL 5'h0c
`define PLC_IDX_TX_LOOP_CODE     5'h0d
`define PLC_IDX_RX_ACTIVATE      5'h0e
`define PLC_IDX_RX_DEACTIVATE    5'h0f
`define PLC_IDX_ERROR_COUNT_CTRL 5'h10
`define PLC_IDX_IRQ_MASK0        5'h11
`define PLC_IDX_IRQ_EDGE_SELECT  5'h13
`define PLC_IDX_STATUS0          5'h14
`define PLC_IDX_STATUS1          5'h15
`define PLC_IDX_IRQ_STATUS0      5'h16
`define PLC_IDX_LINE_MODE        5'h1a

// Field positions
`define PLC_PC_PATTERN_LSB       0
`define PLC_PC_CLOCK_SELECT      2
`define PLC_PC_INVERT            3
`define PLC_LB_ANALOG            0
`define PLC_LB_DIGITAL           1
`define PLC_LB_REMOTE            2
`define PLC_LB_AUTO_REMOTE       3
`define PLC_CL_TX_LSB            0
`define PLC_CL_ACT_LSB           2
`define PLC_CL_DEACT_LSB         4
`define PLC_ST_SEQ_SYNC          0
`define PLC_ST_ACTIVATE          1
`define PLC_ST_DEACTIVATE        2
`define PLC_LM_E1                0

// Reset values
`define PLC_REG_RESET            8'h00
`define PLC_LFSR_SEED            20'h00001

// Checker and detector figures
`define PLC_SYNC_WIN_LAST        6'h3f
`define PLC_SYNC_MAX_ERR         7'h06
`define PLC_QRSS_MAX_ZEROS       5'h0e
`define PLC_CODE_MIN_LEN         4'h5
`define PLC_CODE_BLOCK_LAST      8'hff
`define PLC_CODE_MIN_HITS        9'h080

// Timing: clock rate, times as printed, cycle counts derived in the top module
`define PLC_CLK_MHZ              250
`define PLC_CODE_E1_MS           30
`define PLC_CODE_T1_MS           40
`define PLC_AUTO_LOOP_MS         5100
`endif

// *** rtl/plc_pkg.sv ***
package plc_pkg;

  typedef enum logic [1:0] {
    plc_pat_data = 2'b00,
    plc_pat_ones = 2'b01,
    plc_pat_seq  = 2'b10,
    plc_pat_code = 2'b11
  } plc_pattern_t;

  typedef enum logic [1:0] {
    plc_arl_idle = 2'b01,
    plc_arl_loop = 2'b10
  } plc_arl_state_t;

endpackage : plc_pkg

// *** rtl/plc_maint.sv ***
// Overview of operation
// - Patterns tick on channel transmit clock, or master clock when clock select is 1.
// - Clock select 0 and pattern select 00 pass system transmit data unchanged.
// - Pattern select 01 sends all ones on the selected pattern clock.
// - Clock select 1 with pattern select 00 sends all zeros.
// - Sequence is 2^20-1 with zero limit in T1/J1, 2^15-1 in E1.
// - Pattern select 10 sends the pseudo-random sequence, most significant bit first.
// - Invert bit sends the sequence inverted, else directly.
// - Sync set at 6 or fewer errors per 64-bit window, cleared above 6.
// - Sync rise or any change sets its irq status; irq when status and mask both 1.
// - Error select 00 forwards received sequence errors to the shared 16-bit counter.
// - Analog loopback sends transmit bits to receive outputs while still driving line.
// - Digital loopback sends transmit bits through receive path while still driving line.
// - In analog or digital loopback, selected patterns override transmit data.
// - Remote loopback sends recovered receive clock and data to the transmit line.
// - Pattern select 11 repeats the loop code; stops at clock select 0, select 00.
// - Loop codes are recognised framed or unframed despite one percent bit errors.
// - Auto loop sets after 5.1 s activate, clears after 5.1 s deactivate or enable off.
// - Transmit code is an 8-bit pattern, length 5 to 8 from a two-bit field.
// - Activate and deactivate codes each have 8-bit pattern and own length field.
// - Code status sets after the code is present over 30 ms E1 or 40 ms T1.
// - Edge select 0 captures rises, 1 any change; irq status clears when read.
// - Auto loop establishment sets remote loop status, removal clears it.
`include "plc_params.svh"

// Presence hold timer: held_o once present_i has stood longer than limit_i cycles
module plc_hold_timer (
  // Clock and control
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Presence and threshold
  input  wire logic        present_i,
  input  wire logic [31:0] limit_i,
  output logic             held_o
);
  logic [31:0] count;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count <= 32'h00000000;
    end else if (ce_i) begin
      if (!present_i) begin
        count <= 32'h00000000;
      end else if (count != 32'hffffffff) begin
        count <= count + 32'h00000001;
      end
    end
  end

  assign held_o = present_i && (count > limit_i);
endmodule : plc_hold_timer

module plc_maint
  import plc_pkg::*;
#(
  parameter int unsigned CODE_E1_CYC    = `PLC_CODE_E1_MS * 1000 * `PLC_CLK_MHZ,
  parameter int unsigned CODE_T1_CYC    = `PLC_CODE_T1_MS * 1000 * `PLC_CLK_MHZ,
  parameter int unsigned AUTO_LOOP_CYC  = `PLC_AUTO_LOOP_MS * 1000 * `PLC_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Pins from outside the clock domain
  input  wire logic        channel_tx_clock_i,
  input  wire logic        master_clock_i,
  input  wire logic        sys_tx_data_i,
  input  wire logic        channel_rx_clock_i,
  input  wire logic        rx_data_i,
  // Line side and system side bit streams
  output logic             line_tx_data_o,
  output logic             line_tx_strobe_o,
  output logic             rx_out_data_o,
  output logic             rx_out_strobe_o,
  // To error counter, interrupt, loop state
  output logic             seq_error_count_o,
  output logic             irq_o,
  output logic             remote_loop_active_o
);

  // Configuration registers
  logic [7:0] pattern_ctrl;
  logic [7:0] loopback_ctrl;
  logic [7:0] code_length_ctrl;
  logic [7:0] tx_loop_code;
  logic [7:0] rx_activate_code;
  logic [7:0] rx_deactivate_code;
  logic [7:0] error_count_ctrl;
  logic [7:0] irq_mask0;
  logic [7:0] irq_edge_select;
  logic [7:0] line_mode;
  logic [2:0] irq_status0;
  logic [2:0] status_prev;
  logic       bus_busy;

  plc_pattern_t pattern_select;
  logic       pattern_clock_select;
  logic       seq_invert;
  logic       e1_mode;
  logic       analog_loop_enable;
  logic       digital_loop_enable;
  logic       remote_loop_enable;
  logic       auto_remote_loop_enable;
  logic [1:0] tx_code_length;
  logic [1:0] rx_activate_length;
  logic [1:0] rx_deactivate_length;

  assign pattern_select          = plc_pattern_t'(pattern_ctrl[`PLC_PC_PATTERN_LSB +: 2]);
  assign pattern_clock_select    = pattern_ctrl[`PLC_PC_CLOCK_SELECT];
  assign seq_invert              = pattern_ctrl[`PLC_PC_INVERT];
  assign e1_mode                 = line_mode[`PLC_LM_E1];
  assign analog_loop_enable      = loopback_ctrl[`PLC_LB_ANALOG];
  assign digital_loop_enable     = loopback_ctrl[`PLC_LB_DIGITAL];
  assign remote_loop_enable      = loopback_ctrl[`PLC_LB_REMOTE];
  assign auto_remote_loop_enable = loopback_ctrl[`PLC_LB_AUTO_REMOTE];
  assign tx_code_length          = code_length_ctrl[`PLC_CL_TX_LSB +: 2];
  assign rx_activate_length      = code_length_ctrl[`PLC_CL_ACT_LSB +: 2];
  assign rx_deactivate_length    = code_length_ctrl[`PLC_CL_DEACT_LSB +: 2];

  // Two-flop synchronisers; edges are taken only from the second stage
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      pin_prev <= 5'h00;
    end else if (ce_i) begin
      pin_meta <= {rx_data_i, channel_rx_clock_i, sys_tx_data_i, master_clock_i, channel_tx_clock_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire tx_clk_rise = pin_sync[0] & ~pin_prev[0];
  wire mclk_rise   = pin_sync[1] & ~pin_prev[1];
  wire sys_bit     = pin_sync[2];
  wire rx_clk_rise = pin_sync[3] & ~pin_prev[3];
  wire rx_pin_bit  = pin_sync[4];

  // Pattern bit clock
  wire tx_tick = pattern_clock_select ? mclk_rise : tx_clk_rise;

  // Pseudo-random generator
  logic [19:0] gen_lfsr;
  logic [4:0]  gen_zero_run;
  wire         gen_raw    = e1_mode ? (gen_lfsr[14] ^ gen_lfsr[13]) : (gen_lfsr[19] ^ gen_lfsr[16]);
  // Zero limit keeps line ones density up; receive side tolerates it as rare errors
  wire         gen_forced = !e1_mode && !gen_raw && (gen_zero_run >= `PLC_QRSS_MAX_ZEROS);
  wire         seq_bit    = (gen_raw | gen_forced) ^ seq_invert;
  wire         seq_run    = tx_tick && (pattern_select == plc_pat_seq);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gen_lfsr     <= `PLC_LFSR_SEED;
      gen_zero_run <= 5'h00;
    end else if (ce_i && seq_run) begin
      // New bits enter at the bottom, so the first bit out is the oldest: msb first
      gen_lfsr     <= (gen_lfsr == 20'h00000) ? `PLC_LFSR_SEED : {gen_lfsr[18:0], gen_raw};
      gen_zero_run <= gen_raw ? 5'h00 : (gen_zero_run + ((gen_zero_run == 5'h1f) ? 5'h00 : 5'h01));
    end
  end

  // Loop code generator
  logic [2:0] code_idx;
  wire  [2:0] tx_code_last = 3'(`PLC_CODE_MIN_LEN) + {1'b0, tx_code_length} - 3'h1;
  wire        code_bit     = tx_loop_code[code_idx];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      code_idx <= 3'h0;
    end else if (ce_i) begin
      if (pattern_select != plc_pat_code) begin
        code_idx <= tx_code_last;
      end else if (tx_tick) begin
        code_idx <= (code_idx == 3'h0) ? tx_code_last : (code_idx - 3'h1);
      end
    end
  end

  // Transmit selection
  logic next_tx_bit;

  always_comb begin
    case (pattern_select)
      plc_pat_data: next_tx_bit = pattern_clock_select ? 1'b0 : sys_bit;
      plc_pat_ones: next_tx_bit = 1'b1;
      plc_pat_seq:  next_tx_bit = seq_bit;
      plc_pat_code: next_tx_bit = code_bit;
      default:      next_tx_bit = sys_bit;
    endcase
  end

  // Remote loop state
  plc_arl_state_t arl_state;
  logic           act_long;
  logic           deact_long;
  wire            remote_active = remote_loop_enable || (arl_state == plc_arl_loop);
  wire            local_loop    = analog_loop_enable || digital_loop_enable;

  // Line and receive outputs; analog and digital loops look alike at this level
  // because termination and jitter attenuation sit outside this block
  wire line_tick   = remote_active ? rx_clk_rise : tx_tick;
  wire line_next   = remote_active ? rx_pin_bit : next_tx_bit;
  wire rx_tick     = local_loop ? tx_tick : rx_clk_rise;
  wire rx_bit      = local_loop ? next_tx_bit : rx_pin_bit;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      line_tx_data_o   <= 1'b0;
      line_tx_strobe_o <= 1'b0;
      rx_out_data_o    <= 1'b0;
      rx_out_strobe_o  <= 1'b0;
    end else if (ce_i) begin
      line_tx_strobe_o <= line_tick;
      rx_out_strobe_o  <= rx_tick;
      if (line_tick) begin
        line_tx_data_o <= line_next;
      end
      if (rx_tick) begin
        rx_out_data_o <= rx_bit;
      end
    end
  end

  // Sequence checker: self-synchronising on received bits, 64-bit hopping windows
  logic [19:0] chk_shift;
  logic [5:0]  chk_bit_cnt;
  logic [6:0]  chk_err_cnt;
  logic        seq_sync_status;
  wire         chk_in   = rx_bit ^ seq_invert;
  wire         chk_pred = e1_mode ? (chk_shift[14] ^ chk_shift[13]) : (chk_shift[19] ^ chk_shift[16]);
  wire         chk_err  = rx_tick && (chk_pred != chk_in);
  wire  [6:0]  chk_total = chk_err_cnt + {6'h00, chk_err};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      chk_shift         <= 20'h00000;
      chk_bit_cnt       <= 6'h00;
      chk_err_cnt       <= 7'h00;
      seq_sync_status   <= 1'b0;
      seq_error_count_o <= 1'b0;
    end else if (ce_i) begin
      seq_error_count_o <= chk_err && (error_count_ctrl[1:0] == 2'b00);
      if (rx_tick) begin
        chk_shift   <= {chk_shift[18:0], chk_in};
        chk_bit_cnt <= chk_bit_cnt + 6'h01;
        if (chk_bit_cnt == `PLC_SYNC_WIN_LAST) begin
          seq_sync_status <= (chk_total <= `PLC_SYNC_MAX_ERR);
          chk_err_cnt     <= 7'h00;
        end else begin
          chk_err_cnt     <= chk_total;
        end
      end
    end
  end

  // Loop code detection: any rotation of the repeated code in the last L bits
  function automatic logic code_hit(input logic [7:0] win, input logic [7:0] pat, input logic [1:0] len);
    logic [3:0]  l;
    logic [7:0]  m;
    logic [15:0] rep;
    logic        hit;
    l   = `PLC_CODE_MIN_LEN + {2'b00, len};
    m   = 8'(16'h00ff >> (4'h8 - l));
    rep = ({8'h00, pat & m} << l) | {8'h00, pat & m};
    hit = 1'b0;
    for (int r = 0; r < 8; r++) begin
      if ((r < 32'(l)) && (((win ^ 8'(rep >> r)) & m) == 8'h00)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : code_hit

  logic [7:0] det_win;
  logic [7:0] det_blk_cnt;
  logic [8:0] act_hits;
  logic [8:0] deact_hits;
  logic       act_present;
  logic       deact_present;
  wire        act_hit   = code_hit(det_win, rx_activate_code, rx_activate_length);
  wire        deact_hit = code_hit(det_win, rx_deactivate_code, rx_deactivate_length);

  // A bit error spoils at most eight windows, so half-block hit counts survive
  // a one percent error rate and the odd framing bit
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      det_win       <= 8'h00;
      det_blk_cnt   <= 8'h00;
      act_hits      <= 9'h000;
      deact_hits    <= 9'h000;
      act_present   <= 1'b0;
      deact_present <= 1'b0;
    end else if (ce_i && rx_tick) begin
      det_win     <= {det_win[6:0], rx_bit};
      det_blk_cnt <= det_blk_cnt + 8'h01;
      if (det_blk_cnt == `PLC_CODE_BLOCK_LAST) begin
        act_present   <= (act_hits >= `PLC_CODE_MIN_HITS);
        deact_present <= (deact_hits >= `PLC_CODE_MIN_HITS);
        act_hits      <= 9'h000;
        deact_hits    <= 9'h000;
      end else begin
        act_hits      <= act_hits + {8'h00, act_hit};
        deact_hits    <= deact_hits + {8'h00, deact_hit};
      end
    end
  end

  // Presence timers
  wire [31:0] code_limit = e1_mode ? CODE_E1_CYC : CODE_T1_CYC;
  logic       activate_code_status;
  logic       deactivate_code_status;

  plc_hold_timer u_act_status (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .present_i  (act_present),
    .limit_i    (code_limit),
    .held_o     (activate_code_status)
  );

  plc_hold_timer u_deact_status (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .present_i  (deact_present),
    .limit_i    (code_limit),
    .held_o     (deactivate_code_status)
  );

  plc_hold_timer u_act_auto (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .present_i  (act_present),
    .limit_i    (AUTO_LOOP_CYC),
    .held_o     (act_long)
  );

  plc_hold_timer u_deact_auto (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .present_i  (deact_present),
    .limit_i    (AUTO_LOOP_CYC),
    .held_o     (deact_long)
  );

  // Automatic remote loop
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      arl_state <= plc_arl_idle;
    end else if (ce_i) begin
      case (arl_state)
        plc_arl_idle: if (auto_remote_loop_enable && act_long) arl_state <= plc_arl_loop;
        plc_arl_loop: if (!auto_remote_loop_enable || deact_long) arl_state <= plc_arl_idle;
        default:      arl_state <= plc_arl_idle;
      endcase
    end
  end

  assign remote_loop_active_o = remote_active;

  // Interrupt capture
  wire [2:0] status_now = {deactivate_code_status, activate_code_status, seq_sync_status};
  wire [2:0] irq_event  = (status_now & ~status_prev) |
                          (irq_edge_select[2:0] & (status_now ^ status_prev));

  // Bus slave: one wait cycle, read data captured when the request first appears
  wire        bus_req    = avs_read_i || avs_write_i;
  wire        bus_accept = ce_i && bus_req && bus_busy;
  wire        wr_accept  = bus_accept && avs_write_i && avs_byteenable_i[0];
  wire        rd_accept  = bus_accept && avs_read_i;
  wire [7:0]  wr_byte    = avs_writedata_i[7:0];
  wire [2:0]  irq_clear  = (rd_accept && (avs_address_i == `PLC_IDX_IRQ_STATUS0)) ? avs_readdata_o[2:0] : 3'h0;
  wire [7:0]  rd_mux =
    (avs_address_i == `PLC_IDX_PATTERN_CTRL)     ? pattern_ctrl :
    (avs_address_i == `PLC_IDX_LOOPBACK_CTRL)    ? loopback_ctrl :
    (avs_address_i == `PLC_IDX_CODE_LENGTH_CTRL) ? code_length_ctrl :
    (avs_address_i == `PLC_IDX_TX_LOOP_CODE)     ? tx_loop_code :
    (avs_address_i == `PLC_IDX_RX_ACTIVATE)      ? rx_activate_code :
    (avs_address_i == `PLC_IDX_RX_DEACTIVATE)    ? rx_deactivate_code :
    (avs_address_i == `PLC_IDX_ERROR_COUNT_CTRL) ? error_count_ctrl :
    (avs_address_i == `PLC_IDX_IRQ_MASK0)        ? irq_mask0 :
    (avs_address_i == `PLC_IDX_IRQ_EDGE_SELECT)  ? irq_edge_select :
    (avs_address_i == `PLC_IDX_STATUS0)          ? {5'h00, status_now} :
    (avs_address_i == `PLC_IDX_STATUS1)          ? {7'h00, arl_state == plc_arl_loop} :
    (avs_address_i == `PLC_IDX_IRQ_STATUS0)      ? {5'h00, irq_status0} :
    (avs_address_i == `PLC_IDX_LINE_MODE)        ? line_mode :
    8'h00;

  assign avs_waitrequest_o = bus_req && (!bus_busy || !ce_i);
  assign irq_o             = |(irq_status0 & irq_mask0[2:0]);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bus_busy       <= 1'b0;
      avs_readdata_o <= 32'h00000000;
      irq_status0    <= 3'h0;
      status_prev    <= 3'h0;
    end else if (ce_i) begin
      bus_busy    <= bus_req && !bus_busy;
      status_prev <= status_now;
      // A new event wins over a clear in the same cycle
      irq_status0 <= (irq_status0 & ~irq_clear) | irq_event;
      if (bus_req && !bus_busy) begin
        avs_readdata_o <= {24'h000000, rd_mux};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pattern_ctrl       <= `PLC_REG_RESET;
      loopback_ctrl      <= `PLC_REG_RESET;
      code_length_ctrl   <= `PLC_REG_RESET;
      tx_loop_code       <= `PLC_REG_RESET;
      rx_activate_code   <= `PLC_REG_RESET;
      rx_deactivate_code <= `PLC_REG_RESET;
      error_count_ctrl   <= `PLC_REG_RESET;
      irq_mask0          <= `PLC_REG_RESET;
      irq_edge_select    <= `PLC_REG_RESET;
      line_mode          <= `PLC_REG_RESET;
    end else if (wr_accept) begin
      if (avs_address_i == `PLC_IDX_PATTERN_CTRL) begin
        pattern_ctrl <= wr_byte;
      end else if (avs_address_i == `PLC_IDX_LOOPBACK_CTRL) begin
        loopback_ctrl <= wr_byte;
      end else if (avs_address_i == `PLC_IDX_CODE_LENGTH_CTRL) begin
        code_length_ctrl <= wr_byte;
      end else if (avs_address_i == `PLC_IDX_TX_LOOP_CODE) begin
        tx_loop_code <= wr_byte;
      end else if (avs_address_i == `PLC_IDX_RX_ACTIVATE) begin
        rx_activate_code <= wr_byte;
      end else if (avs_address_i == `PLC_IDX_RX_DEACTIVATE) begin
        rx_deactivate_code <= wr_byte;
      end else if (avs_address_i == `PLC_IDX_ERROR_COUNT_CTRL) begin
        error_count_ctrl <= wr_byte;
      end else if (avs_address_i == `PLC_IDX_IRQ_MASK0) begin
        irq_mask0 <= wr_byte;
      end else if (avs_address_i == `PLC_IDX_IRQ_EDGE_SELECT) begin
        irq_edge_select <= wr_byte;
      end else if (avs_address_i == `PLC_IDX_LINE_MODE) begin
        line_mode <= wr_byte;
      end
    end
  end

endmodule : plc_maint

// *** tb/plc_maint_asserts.sv ***
module plc_maint_asserts (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Streams and status
  input wire logic        line_tx_data_o,
  input wire logic        line_tx_strobe_o,
  input wire logic        rx_out_data_o,
  input wire logic        rx_out_strobe_o,
  input wire logic        seq_error_count_o,
  input wire logic        irq_o,
  input wire logic        remote_loop_active_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow copies of the registers; bits still in flight after a write are ignored
  logic [7:0] shd [32];
  logic [3:0] quiet;
  wire        acc  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  wire        calm = quiet == 4'hf;
  wire [7:0]  pat  = shd[5'h0a];
  wire [7:0]  lb   = shd[5'h0b];
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < 32; k++) shd[k] <= 8'h00;
      quiet <= 4'h0;
    end else begin
      if (acc) shd[avs_address_i] <= avs_writedata_i[7:0];
      quiet <= acc ? 4'h0 : quiet + {3'h0, !calm};
    end
  end
  sequence wait_once_s;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  bus_wait_one_a: assert property ($rose(avs_read_i || avs_write_i) |-> wait_once_s)
    else $error("wait state count wrong");
  read_upper_a: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  all_ones_a: assert property (
    calm && pat[1:0] == 2'b01 && !remote_loop_active_o && line_tx_strobe_o |-> line_tx_data_o)
    else $error("zero sent during all ones");
  all_zeros_a: assert property (
    calm && pat[2:0] == 3'b100 && !remote_loop_active_o && line_tx_strobe_o |-> !line_tx_data_o)
    else $error("one sent during all zeros");
  err_select_a: assert property (calm && shd[5'h10][1:0] != 2'b00 |-> !seq_error_count_o)
    else $error("sequence error counted while not selected");
  loop_rx_a: assert property (
    calm && lb[1:0] != 2'b00 && !remote_loop_active_o && rx_out_strobe_o
    |-> line_tx_strobe_o && rx_out_data_o == line_tx_data_o)
    else $error("looped bit differs from line bit");
  remote_loop_a: assert property (calm && !lb[3] |-> remote_loop_active_o == lb[2])
    else $error("remote loop state wrong");
  irq_mask_a: assert property (calm && shd[5'h11][2:0] == 3'h0 |-> !irq_o)
    else $error("interrupt while all masked");
endmodule : plc_maint_asserts

bind plc_maint plc_maint_asserts u_chk (.*);

// *** tb/plc_far_end.sv ***
module plc_far_end (
  // Control from the bench
  input  wire logic       run_i,
  input  wire logic [7:0] code_i,
  input  wire logic [3:0] len_i,
  // Line towards the receiver
  output logic            rx_clk_o,
  output logic            rx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned idx;
  initial begin
    rx_clk_o  = 1'b0;
    rx_data_o = 1'b0;
    idx       = 0;
    forever begin
      if (run_i) begin
        rx_data_o = code_i[len_i - 1 - idx];
        idx = (idx + 1) % len_i;
        #16 rx_clk_o = 1'b1;
        #16 rx_clk_o = 1'b0;
      end else begin
        // Clock stands still between bursts, data must not look valid
        rx_data_o = ~rx_data_o;
        idx = 0;
        #4;
      end
    end
  end
endmodule : plc_far_end

// *** tb/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i, rst_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic        channel_tx_clock_i, master_clock_i, sys_tx_data_i, channel_rx_clock_i, rx_data_i;
  logic        line_tx_data_o, line_tx_strobe_o, rx_out_data_o, rx_out_strobe_o;
  logic        seq_error_count_o, remote_loop_active_o, tx_run, far_run;
  logic [4:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, v;
  logic [3:0]  avs_byteenable_i, far_len;
  logic [7:0]  far_code;
  int          mismatches = 0, checks_done = 0, cyc = 0, i, c;

  plc_maint #(.CODE_E1_CYC(1500), .CODE_T1_CYC(2000), .AUTO_LOOP_CYC(4000)) uut (.*);
  plc_far_end far (.run_i(far_run), .code_i(far_code), .len_i(far_len), .rx_clk_o(channel_rx_clock_i),
                   .rx_data_o(rx_data_i));

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // Transmit clock 8 cycles a bit and stoppable, master clock 10 cycles a bit
  always @(posedge core_clk_i) begin
    cyc++;
    if (tx_run && cyc % 4 == 0) channel_tx_clock_i <= ~channel_tx_clock_i;
    if (cyc % 5 == 0) master_clock_i <= ~master_clock_i;
    if (cyc == 60000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    avs_address_i   <= a;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    avs_writedata_i <= {24'h0, d};
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge core_clk_i);
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("register", q & {24'h0, m}, {24'h0, e});
  endtask : rd

  // Skips four bits that may predate the last write, then collects n line bits
  task automatic bits(input int n);
    v = 32'h0;
    for (i = 0; i < n + 4; i++) begin
      do @(posedge core_clk_i); while (line_tx_strobe_o !== 1'b1);
      v = {v[30:0], line_tx_data_o};
    end
  endtask : bits

  task automatic count();
    c = 0;
    repeat (400) begin
      @(posedge core_clk_i);
      c += int'(line_tx_strobe_o);
    end
  endtask : count

  initial begin
    {rst_i, ce_i, avs_byteenable_i} = 6'h3f;
    {avs_read_i, avs_write_i, channel_tx_clock_i, master_clock_i, sys_tx_data_i, tx_run, far_run} = '0;
    {avs_address_i, avs_writedata_i, far_code, far_len} = {5'h00, 32'h0, 8'h01, 4'h5};
    repeat (6) @(posedge core_clk_i);
    rst_i  <= 1'b0;
    tx_run <= 1'b1;
    @(posedge core_clk_i);
    for (int k = 10; k < 23; k++) rd(5'(k), 8'hff, 8'h00);
    bus(1'b1, 5'h12, 8'hff);
    rd(5'h12, 8'hff, 8'h00);
    for (int k = 13; k < 16; k++) begin
      bus(1'b1, 5'(k), 8'ha5);
      rd(5'(k), 8'hff, 8'ha5);
    end
    sys_tx_data_i <= 1'b1;
    bits(16);
    chk("normal data", v[15:0], 16'hffff);
    bus(1'b1, 5'h0a, 8'h01);
    sys_tx_data_i <= 1'b0;
    bits(16);
    chk("all ones", v[15:0], 16'hffff);
    tx_run <= 1'b0;
    bus(1'b1, 5'h0a, 8'h04);
    bits(16);
    chk("all zeros", v[15:0], 16'h0000);
    bus(1'b1, 5'h0a, 8'h01);
    count();
    chk("ticks with transmit clock stopped", c, 0);
    bus(1'b1, 5'h0a, 8'h05);
    count();
    chk("ticks on master clock", c > 30, 1);
    tx_run <= 1'b1;
    bus(1'b1, 5'h0d, 8'h80);
    bus(1'b1, 5'h0c, 8'h03);
    bus(1'b1, 5'h0a, 8'h03);
    bits(16);
    chk("eight bit code", $countones(v[15:0]), 2);
    bus(1'b1, 5'h0d, 8'h10);
    bus(1'b1, 5'h0c, 8'h00);
    bits(20);
    chk("five bit code", $countones(v[19:0]), 4);
    bus(1'b1, 5'h0a, 8'h00);
    sys_tx_data_i <= 1'b1;
    bits(16);
    chk("code stopped", v[15:0], 16'hffff);
    bus(1'b1, 5'h11, 8'h01);
    bus(1'b1, 5'h0b, 8'h01);
    bus(1'b1, 5'h0a, 8'h02);
    repeat (3000) @(posedge core_clk_i);
    rd(5'h14, 8'h01, 8'h01);
    chk("irq raised", irq_o, 1'b1);
    rd(5'h16, 8'hff, 8'h01);
    rd(5'h16, 8'hff, 8'h00);
    chk("irq cleared", irq_o, 1'b0);
    bus(1'b1, 5'h0b, 8'h02);
    bus(1'b1, 5'h1a, 8'h01);
    bus(1'b1, 5'h0a, 8'h0a);
    repeat (3000) @(posedge core_clk_i);
    rd(5'h14, 8'h01, 8'h01);
    bus(1'b1, 5'h10, 8'h01);
    bus(1'b1, 5'h0b, 8'h08);
    bus(1'b1, 5'h0a, 8'h00);
    bus(1'b1, 5'h13, 8'h06);
    bus(1'b1, 5'h0e, 8'h01);
    bus(1'b1, 5'h0f, 8'h09);
    bus(1'b1, 5'h0c, 8'h10);
    rd(5'h16, 8'h00, 8'h00);
    far_run <= 1'b1;
    for (i = 0; i < 20000 && remote_loop_active_o !== 1'b1; i++) @(posedge core_clk_i);
    rd(5'h15, 8'h01, 8'h01);
    rd(5'h14, 8'h06, 8'h02);
    far_code <= 8'h09;
    far_len  <= 4'h6;
    for (i = 0; i < 20000 && remote_loop_active_o !== 1'b0; i++) @(posedge core_clk_i);
    rd(5'h15, 8'h01, 8'h00);
    rd(5'h14, 8'h06, 8'h04);
    rd(5'h16, 8'h06, 8'h06);
    finish_test();
  end
endmodule : testbench
